// File: rtl/quirk_pkg.sv
// Notes on behaviour
// - Pop-multiple writing status into low power with interrupt pending hangs the CPU.
// - Indirect read through the program counter drops the following instruction.
// - Jump followed by word 0X40h or 0X50h adds an extra 2 to PC.
// - Pop-multiple issues one unintended read after its final stack-pointer increment.
// - That read on vacant memory sets the flag; enabled flag requests an interrupt.
// - The unintended read hits vacant memory only when pops reach stack top.
// - PC-modifying fetch from a region end without following region sets flag falsely.
// - False flag window is last 8 bytes under breakpoints, else last 4 bytes.
// - Non-PC-modifying instructions and data in those bytes never set the flag.
// - A no-operation word between jump and following word avoids the extra increment.
package quirk_pkg;

  typedef logic [15:0] word_type;

  // Word that follows a jump: upper nibble zero, second nibble ignored, low byte matched.
  localparam word_type JUMP_FOLLOW_MASK = 16'hF0FF;
  localparam word_type JUMP_FOLLOW_A = 16'h0040;
  localparam word_type JUMP_FOLLOW_B = 16'h0050;
  localparam word_type PC_EXTRA_STEP = 16'h0002;
  localparam word_type NOP_WORD = 16'h4303;
  localparam word_type ZERO_WORD = 16'h0000;
  localparam word_type BYTE_STEP = 16'h0001;

  // Span of the false-flag window at a region end, in bytes.
  localparam word_type TAIL_BYTES_DEBUG = 16'h0008;
  localparam word_type TAIL_BYTES_RUN = 16'h0004;

  // Implemented memory ranges, inclusive byte addresses.
  localparam int NUM_REGIONS = 3;
  localparam word_type REGION_BASE [NUM_REGIONS] = '{16'h1800, 16'h1C00, 16'h4400};
  localparam word_type REGION_LAST [NUM_REGIONS] = '{16'h19FF, 16'h23FF, 16'hFFFF};

  // Stack pointer value once every word of the stack area has been popped.
  localparam word_type STACK_TOP_ADDR = 16'h2400;

  typedef enum logic [2:0] {
    kind_other,
    kind_jump,
    kind_pop_multiple,
    kind_indirect_pc,
    kind_pc_modify
  } instr_kind_type;

endpackage

// File: rtl/region_check.sv
`timescale 1ns/10ps
`default_nettype none
module region_check
  import quirk_pkg::*;
(
  // Address under test.
  input wire logic [15:0] addr,
  input wire logic debug_break_mode,
  // Classification.
  output logic vacant,
  output logic tail_hit
);

  // True when another implemented region starts right after region i.
  function automatic logic region_followed(int i);
    logic hit;
    hit = 1'b0;
    for (int j = 0; j < NUM_REGIONS; j++) begin
      if (REGION_BASE[j] == REGION_LAST[i] + BYTE_STEP) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // True when the address lies in no implemented range.
  function automatic logic addr_vacant(word_type a);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_REGIONS; i++) begin
      if (a >= REGION_BASE[i] && a <= REGION_LAST[i]) begin
        hit = 1'b1;
      end
    end
    return ~hit;
  endfunction

  // True when the address lies in the last span bytes of a region with a gap above it.
  function automatic logic addr_tail(word_type a, word_type span);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_REGIONS; i++) begin
      if (!region_followed(i) && a >= REGION_BASE[i] && a <= REGION_LAST[i] &&
          a >= REGION_LAST[i] - (span - BYTE_STEP)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // Window width depends on whether breakpoint debugging is active.
  wire word_type tail_span = debug_break_mode ? TAIL_BYTES_DEBUG : TAIL_BYTES_RUN;
  assign vacant = addr_vacant(addr);
  assign tail_hit = addr_tail(addr, tail_span);

endmodule
`default_nettype wire

// File: rtl/cpu_quirk_model.sv
`timescale 1ns/10ps
`default_nettype none
module cpu_quirk_model
  import quirk_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Executed instruction stream from the decoder.
  input wire logic instr_valid,
  input wire instr_kind_type instr_kind,
  input wire logic [15:0] instr_addr,
  input wire logic [15:0] instr_next_word,
  input wire logic instr_writes_lpm,
  input wire logic [15:0] final_sp,
  // Core state.
  input wire logic irq_pending,
  input wire logic debug_break_mode,
  // Vacant-access control from the special function registers.
  input wire logic vacant_access_irq_enable,
  input wire logic vacant_flag_clear,
  // Effects on the core.
  output logic instr_squash,
  output logic pc_extra_valid,
  output logic [15:0] pc_extra_add,
  output logic spurious_rd_en,
  output logic [15:0] spurious_rd_addr,
  output logic cpu_hung,
  // Vacant-access status.
  output logic vacant_access_flag,
  output logic vacant_irq
);

  logic skip_pending_reg;
  logic skip_pending_next;
  logic hung_reg;
  logic hung_next;
  logic extra_reg;
  logic extra_next;
  logic rd_en_reg;
  logic rd_en_next;
  logic [15:0] rd_addr_reg;
  logic [15:0] rd_addr_next;
  logic flag_reg;
  logic flag_next;
  logic fetch_tail;
  logic read_vacant;

  // An instruction takes effect unless it is the dropped slot or the core is hung.
  wire exec_valid = instr_valid & ~skip_pending_reg & ~hung_reg;
  wire is_jump = instr_kind == kind_jump;
  wire is_pop = instr_kind == kind_pop_multiple;
  wire is_indirect = instr_kind == kind_indirect_pc;
  wire is_pc_mod = is_jump | (instr_kind == kind_pc_modify);

  // Low byte 40h or 50h with zero top nibble; a no-operation word never matches.
  wire word_type follow_masked = word_type'(instr_next_word & JUMP_FOLLOW_MASK);
  wire follow_match = (follow_masked == JUMP_FOLLOW_A) | (follow_masked == JUMP_FOLLOW_B);
  assign extra_next = exec_valid & is_jump & follow_match;

  // The slot after a PC-indirect read is dropped once, then normal flow resumes.
  assign instr_squash = instr_valid & skip_pending_reg & ~hung_reg;
  assign skip_pending_next = (exec_valid & is_indirect) |
                             (skip_pending_reg & ~instr_squash);

  // Pop-multiple into low power with a pending request locks the core until reset.
  wire hang_event = exec_valid & is_pop & instr_writes_lpm & irq_pending;
  assign hung_next = hung_reg | hang_event;

  // Every pop-multiple reads once more at the stack pointer left after its last pop.
  wire pop_event = exec_valid & is_pop;
  assign rd_en_next = pop_event;
  assign rd_addr_next = rd_en_next ? final_sp : rd_addr_reg;

  // Region classification of the fetch address and of the unintended read.
  region_check u_fetch_check (
    .addr(instr_addr),
    .debug_break_mode(debug_break_mode),
    .vacant(),
    .tail_hit(fetch_tail)
  );

  region_check u_read_check (
    .addr(rd_addr_reg),
    .debug_break_mode(debug_break_mode),
    .vacant(read_vacant),
    .tail_hit()
  );

  // Only PC-modifying fetches count at a region end; data and other opcodes do not.
  wire false_event = exec_valid & is_pc_mod & fetch_tail;
  // The read only lands in vacant space when the pops ran up to the stack top.
  wire read_event = rd_en_reg & read_vacant;
  // Setting wins over a clear in the same cycle.
  wire flag_event = false_event | read_event;
  assign flag_next = (flag_reg & ~vacant_flag_clear) | flag_event;

  // Sequential state.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      skip_pending_reg <= 1'b0;
      hung_reg <= 1'b0;
      extra_reg <= 1'b0;
      rd_en_reg <= 1'b0;
      rd_addr_reg <= ZERO_WORD;
      flag_reg <= 1'b0;
    end else begin
      skip_pending_reg <= skip_pending_next;
      hung_reg <= hung_next;
      extra_reg <= extra_next;
      rd_en_reg <= rd_en_next;
      rd_addr_reg <= rd_addr_next;
      flag_reg <= flag_next;
    end
  end

  // Outputs.
  assign pc_extra_valid = extra_reg;
  assign pc_extra_add = extra_reg ? PC_EXTRA_STEP : ZERO_WORD;
  assign spurious_rd_en = rd_en_reg;
  assign spurious_rd_addr = rd_addr_reg;
  assign cpu_hung = hung_reg;
  assign vacant_access_flag = flag_reg;
  assign vacant_irq = flag_reg & vacant_access_irq_enable;

  // Checks on the modelled behaviour.
  default clocking chk_clk @(posedge clk);
  endclocking
  default disable iff (reset);

  chk_hang_entry: assert property (
    exec_valid && is_pop && instr_writes_lpm && irq_pending |=> cpu_hung [*3])
    else $error("Core did not hang after pop into low power with pending request.");

  chk_hang_cause: assert property (
    $rose(cpu_hung) |-> $past(hang_event))
    else $error("Core hung without the pop-into-low-power cause.");

  chk_skip_slot: assert property (
    exec_valid && is_indirect ##1 instr_valid |-> instr_squash ##1 !pc_extra_valid && !spurious_rd_en)
    else $error("Instruction after indirect PC read was not dropped.");

  chk_extra_step: assert property (
    exec_valid && is_jump && follow_match |=> pc_extra_valid && pc_extra_add == PC_EXTRA_STEP)
    else $error("Jump with matching follow word gave no extra increment of 2.");

  chk_nop_guard: assert property (
    exec_valid && is_jump && instr_next_word == NOP_WORD |=> pc_extra_add == ZERO_WORD)
    else $error("No-operation after jump still gave an extra increment.");

  chk_pop_read: assert property (
    pop_event |=> spurious_rd_en && spurious_rd_addr == $past(final_sp) ##1
      !spurious_rd_en || $past(pop_event))
    else $error("Pop-multiple did not issue its single extra read at the final pointer.");

  chk_read_top: assert property (
    spurious_rd_en && read_vacant |-> spurious_rd_addr == STACK_TOP_ADDR)
    else $error("Extra read reached vacant memory away from the stack top.");

  chk_read_flag: assert property (
    spurious_rd_en && read_vacant |=> vacant_access_flag && (vacant_irq == vacant_access_irq_enable))
    else $error("Vacant extra read did not set the flag and request.");

  chk_tail_flag: assert property (
    exec_valid && is_pc_mod && fetch_tail |=> vacant_access_flag)
    else $error("PC-modifying fetch at a region end did not set the flag.");

  chk_flag_cause: assert property (
    $rose(vacant_access_flag) |-> $past(flag_event))
    else $error("Vacant flag set without a qualifying event.");

  chk_flag_sticky: assert property (
    vacant_access_flag && !vacant_flag_clear |=> vacant_access_flag)
    else $error("Vacant flag dropped without a clear.");

  // Effects that must stay quiet once the core is hung or a slot is dropped.
  chk_hung_inert: assert property (
    cpu_hung |-> !instr_squash ##1 !pc_extra_valid && !spurious_rd_en)
    else $error("Hung core still showed an instruction effect.");

  chk_hang_hold: assert property (
    cpu_hung |=> cpu_hung)
    else $error("Hung core recovered without a reset.");

  chk_squash_effect: assert property (
    instr_squash |=> !pc_extra_valid && !spurious_rd_en)
    else $error("Dropped instruction still had an effect.");

  chk_extra_cause: assert property (
    pc_extra_valid |-> ($past(follow_masked) == JUMP_FOLLOW_A) ||
                       ($past(follow_masked) == JUMP_FOLLOW_B))
    else $error("Extra increment without a matching follow word.");

  chk_extra_idle: assert property (
    !pc_extra_valid |-> pc_extra_add == ZERO_WORD)
    else $error("Extra increment amount shown without the valid pulse.");

  chk_read_cause: assert property (
    spurious_rd_en |-> $past(pop_event) && spurious_rd_addr == $past(final_sp))
    else $error("Extra read without a pop-multiple before it.");

  chk_irq_gate: assert property (
    vacant_irq |-> vacant_access_flag && vacant_access_irq_enable)
    else $error("Vacant request raised without flag and enable.");

  chk_plain_tail: assert property (
    exec_valid && !is_pc_mod && fetch_tail && !read_event && !vacant_access_flag
      |=> !vacant_access_flag)
    else $error("Plain instruction at a region end set the flag.");

  chk_set_wins: assert property (
    flag_event |=> vacant_access_flag)
    else $error("Vacant flag event lost, even against a clear.");

  chk_flag_clear: assert property (
    vacant_flag_clear && !flag_event |=> !vacant_access_flag)
    else $error("Vacant flag survived a clear with no new event.");

  cov_hang: cover property (exec_valid && is_pop && instr_writes_lpm && irq_pending ##1 cpu_hung);
  cov_extra: cover property (pc_extra_valid);
  cov_stack_top: cover property (spurious_rd_en && read_vacant);
  cov_tail: cover property (false_event && debug_break_mode);
  cov_set_wins: cover property (flag_event && vacant_flag_clear);

endmodule
`default_nettype wire

// File: test/sys_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module sys_mem_model
  import quirk_pkg::*;
(
  // Fetch address of the executed instruction.
  input wire logic [15:0] instr_addr,
  // Word stored right after that instruction.
  output logic [15:0] next_word
);
  // Small word-addressed program window, preset to no-operation words.
  word_type mem [256];
  initial begin
    foreach (mem[i]) begin
      mem[i] = NOP_WORD;
    end
  end
  // The window wraps, so any fetch address sees a defined word.
  assign next_word = mem[instr_addr[8:1] + 8'h01];
endmodule
`default_nettype wire

// File: test/cpu_stack_jump_vacant_quirks_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module cpu_stack_jump_vacant_quirks_tb_top;
  import quirk_pkg::*;
  logic clk, reset, instr_valid, instr_writes_lpm, irq_pending, debug_break_mode, sq;
  logic vacant_access_irq_enable, vacant_flag_clear, instr_squash, pc_extra_valid;
  logic spurious_rd_en, cpu_hung, vacant_access_flag, vacant_irq;
  logic [15:0] instr_addr, final_sp, instr_next_word, pc_extra_add, spurious_rd_addr;
  instr_kind_type instr_kind;
  int err_count, cmp_count;
  word_type jw [6] = '{16'h0140, 16'h0F50, 16'h0050, 16'h4303, 16'h0141, 16'h1040};
  logic je [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

  sys_mem_model mem_i (.instr_addr(instr_addr), .next_word(instr_next_word));
  cpu_quirk_model dut (.clk(clk), .reset(reset), .instr_valid(instr_valid),
    .instr_kind(instr_kind), .instr_addr(instr_addr), .instr_next_word(instr_next_word),
    .instr_writes_lpm(instr_writes_lpm), .final_sp(final_sp), .irq_pending(irq_pending),
    .debug_break_mode(debug_break_mode), .vacant_access_irq_enable(vacant_access_irq_enable),
    .vacant_flag_clear(vacant_flag_clear), .instr_squash(instr_squash),
    .pc_extra_valid(pc_extra_valid), .pc_extra_add(pc_extra_add),
    .spurious_rd_en(spurious_rd_en), .spurious_rd_addr(spurious_rd_addr), .cpu_hung(cpu_hung),
    .vacant_access_flag(vacant_access_flag), .vacant_irq(vacant_irq));

  // Free-running clock at 25 ns.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Prints the counts and the verdict, then stops.
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Presents one instruction; sq keeps the drop indication of its cycle.
  task automatic issue(input instr_kind_type k, input logic [15:0] a, input logic [15:0] sp,
                       input logic low_power_state);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_kind <= k;
    instr_addr <= a;
    final_sp <= sp;
    instr_writes_lpm <= low_power_state;
    #1 sq = instr_squash;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  // Pulses the software clear and confirms the flag drops.
  task automatic clear_flag();
    @(posedge clk);
    vacant_flag_clear <= 1'b1;
    @(posedge clk);
    vacant_flag_clear <= 1'b0;
    #1 `CHK("flag clear", 1'b0, vacant_access_flag)
  endtask

  // Jumps followed by matching and non-matching words, a no-operation among them.
  task automatic jump_test();
    for (int i = 0; i < 6; i++) begin
      mem_i.mem[8'h0C] = jw[i];
      issue(kind_jump, 16'h8016, 16'h0000, 1'b0);
      `CHK("extra valid", je[i], pc_extra_valid)
      `CHK("extra add", je[i] ? PC_EXTRA_STEP : ZERO_WORD, pc_extra_add)
    end
  endtask

  // The instruction after an indirect program-counter read is dropped, then flow resumes.
  task automatic indirect_test();
    mem_i.mem[8'h0C] = 16'h0140;
    issue(kind_indirect_pc, 16'h8010, 16'h0000, 1'b0);
    `CHK("no drop", 1'b0, sq)
    issue(kind_jump, 16'h8016, 16'h0000, 1'b0);
    `CHK("dropped", 1'b1, sq)
    `CHK("dropped effect", 1'b0, pc_extra_valid)
    issue(kind_jump, 16'h8016, 16'h0000, 1'b0);
    `CHK("resumed", 1'b1, pc_extra_valid)
    @(posedge clk);
    #1 `CHK("extra pulse", 1'b0, pc_extra_valid)
    // Indirect read and a matching jump presented back to back.
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_kind <= kind_indirect_pc;
    @(posedge clk);
    instr_kind <= kind_jump;
    #1 `CHK("back to back drop", 1'b1, instr_squash)
    @(posedge clk);
    instr_valid <= 1'b0;
    #1 `CHK("back to back effect", 1'b0, pc_extra_valid)
    mem_i.mem[8'h0C] = NOP_WORD;
  endtask

  // Multiple pop short of and up to the stack top, with the interrupt enable.
  task automatic pop_test();
    issue(kind_pop_multiple, 16'h4400, 16'h2000, 1'b0);
    `CHK("rd en", 1'b1, spurious_rd_en)
    `CHK("rd addr", 16'h2000, spurious_rd_addr)
    @(posedge clk);
    #1 `CHK("flag mid", 1'b0, vacant_access_flag)
    `CHK("rd pulse", 1'b0, spurious_rd_en)
    issue(kind_pop_multiple, 16'h4400, STACK_TOP_ADDR, 1'b0);
    `CHK("rd top", STACK_TOP_ADDR, spurious_rd_addr)
    @(posedge clk);
    #1 `CHK("flag top", 1'b1, vacant_access_flag)
    `CHK("irq off", 1'b0, vacant_irq)
    @(posedge clk);
    vacant_access_irq_enable <= 1'b1;
    #1 `CHK("irq on", 1'b1, vacant_irq)
    `CHK("flag held", 1'b1, vacant_access_flag)
    clear_flag();
    `CHK("irq cleared", 1'b0, vacant_irq)
  endtask

  // One fetch near a region end; a raised flag is cleared afterwards.
  task automatic tail(input instr_kind_type k, input logic [15:0] a, input logic d,
                      input logic e);
    @(posedge clk);
    debug_break_mode <= d;
    issue(k, a, 16'h0000, 1'b0);
    `CHK("tail flag", e, vacant_access_flag)
    if (e) begin
      clear_flag();
    end
  endtask

  // Region-end windows in both modes, for modifying and plain instructions.
  task automatic tail_test();
    tail(kind_jump, 16'h19FC, 1'b0, 1'b1);
    tail(kind_jump, 16'h19F8, 1'b0, 1'b0);
    tail(kind_jump, 16'h19F8, 1'b1, 1'b1);
    tail(kind_pc_modify, 16'h23FE, 1'b0, 1'b1);
    tail(kind_other, 16'h19FE, 1'b1, 1'b0);
    tail(kind_jump, 16'h1BFE, 1'b0, 1'b0);
    // A region-end event in the same cycle as a clear keeps the flag set.
    @(posedge clk);
    vacant_flag_clear <= 1'b1;
    issue(kind_jump, 16'h19FC, 16'h0000, 1'b0);
    `CHK("set beats clear", 1'b1, vacant_access_flag)
    clear_flag();
  endtask

  // Low-power pop hangs only with an interrupt pending; reset recovers.
  task automatic hang_test();
    issue(kind_pop_multiple, 16'h4400, 16'h2000, 1'b1);
    `CHK("no hang", 1'b0, cpu_hung)
    @(posedge clk);
    irq_pending <= 1'b1;
    issue(kind_pop_multiple, 16'h4400, 16'h2000, 1'b1);
    `CHK("hung", 1'b1, cpu_hung)
    mem_i.mem[8'h0C] = 16'h0140;
    issue(kind_jump, 16'h8016, 16'h0000, 1'b0);
    `CHK("ignored", 1'b0, pc_extra_valid)
    @(posedge clk);
    reset <= 1'b1;
    irq_pending <= 1'b0;
    @(posedge clk);
    reset <= 1'b0;
    #1 `CHK("recovered", 1'b0, cpu_hung)
    issue(kind_jump, 16'h8016, 16'h0000, 1'b0);
    `CHK("jump after reset", 1'b1, pc_extra_valid)
  endtask

  // Watchdog well beyond the expected run length.
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    summarize();
  end

  // Main sequence.
  initial begin
    reset = 1'b1;
    instr_valid = 1'b0;
    instr_kind = kind_other;
    instr_addr = 16'h0000;
    final_sp = 16'h0000;
    instr_writes_lpm = 1'b0;
    irq_pending = 1'b0;
    debug_break_mode = 1'b0;
    vacant_access_irq_enable = 1'b0;
    vacant_flag_clear = 1'b0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    jump_test();
    indirect_test();
    pop_test();
    tail_test();
    hang_test();
    summarize();
  end
endmodule
`default_nettype wire
